// [odl_defs.svh]
// Register indexes, field positions and reset values of the output dependency logic
`ifndef ODL_DEFS_SVH
`define ODL_DEFS_SVH
// Register indexes; the byte address is four times the index
`define ODL_IDX_D_T1_PRI 8'h1D
`define ODL_IDX_D_T1_SEC 8'h1E
`define ODL_IDX_D_T1_IO 8'h1F
`define ODL_IDX_D_T2_PRI 8'h20
`define ODL_IDX_D_T2_SEC 8'h21
`define ODL_IDX_D_T2_IO 8'h22
`define ODL_IDX_H_BITS_A 8'h23
`define ODL_IDX_E_T1_PRI 8'h24
`define ODL_IDX_E_T1_SEC 8'h25
`define ODL_IDX_E_T1_IO 8'h26
`define ODL_IDX_E_T2_PRI 8'h27
`define ODL_IDX_E_T2_SEC 8'h28
`define ODL_IDX_E_T2_IO 8'h29
`define ODL_IDX_H_BITS_B 8'h2A
`define ODL_IDX_E_T2_H 8'h3B
`define ODL_IDX_MR_EN 8'h40
`define ODL_IDX_STATUS 8'h50
// Field positions
`define ODL_BIT_D_T1_H 0
`define ODL_BIT_D_T2_H 1
`define ODL_BIT_E_T1_H 0
`define ODL_BIT_E_T2_H 4
`define ODL_BIT_MR_D 3
`define ODL_BIT_MR_E 4
// Reset value of every mask register
`define ODL_MASK_RST 8'h00
`endif

// [odl_pkg.sv]
// Types of the output dependency logic
package odl_pkg;
   // Mask bytes of one product term
   typedef struct packed {
      logic [7:0] pri;
      logic [7:0] sec;
      logic [7:0] io;
   } odl_term_t;

   // Whole state of the block
   typedef struct packed {
      odl_term_t dT1;
      odl_term_t dT2;
      odl_term_t eT1;
      odl_term_t eT2;
      logic [7:0] hBitsA;
      logic [7:0] hBitsB;
      logic [7:0] eT2H;
      logic [7:0] mrEn;
      logic outD;
      logic outE;
      logic ack;
      logic [31:0] rdata;
   } odl_state_t;
endpackage

// [odl_output_dependency.sv]
// Dependency masks and assertion logic of programmable outputs D and E
//
// Overview of operation
// - Reg 20h bits 0-5 tie D term 2 to primary thresholds A-F.
// - Reg 20h bits 6 and 7 tie D term 2 to watchdogs one, two.
// - Reg 21h bits 0-5 tie D term 2 to secondary thresholds A-F.
// - Reg 21h bits 6-7, 22h bits 0-1 tie D term 2 to gp inputs A-D.
// - Reg 22h bits 2-7 tie D term 2 to outputs A,B,C,E,F,G.
// - Reg 23h bit 1 ties D term 2 to output H.
// - Reg 40h bit 3 set asserts D while manual reset is low.
// - A zero mask bit removes that source from the term.
// - D deasserts when either of its product terms is one.
// - Reg 24h ties E term 1 to primary thresholds A-F, watchdogs.
// - Reg 25h bits 0-5 tie E term 1 to secondary thresholds A-F.
// - Reg 25h bits 6-7, 26h bits 0-1 tie E term 1 to gp inputs.
// - Reg 26h bits 2-7 tie E term 1 to outputs A,B,C,D,F,G.
// - Reg 2Ah bit 0 ties E term 1 to output H.
// - Reg 40h bit 4 set asserts E while manual reset is low.
// - D term 1 uses 1Dh-1Fh, its H bit in 23h bit 0.
// - E term 2 uses 27h-29h, H bit in 3Bh; either term deasserts E.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "odl_defs.svh"

module odl_output_dependency (
   input wire logic refClk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [9:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   input wire logic [5:0] monPriOk,
   input wire logic [5:0] monSecOk,
   input wire logic [1:0] wdogOk,
   input wire logic [3:0] gpInput,
   input wire logic outAAssert,
   input wire logic outBAssert,
   input wire logic outCAssert,
   input wire logic outFAssert,
   input wire logic outGAssert,
   input wire logic outHAssert,
   input wire logic manualResetN,
   output logic outDAssert,
   output logic outEAssert
);

   // ==========================================================
   // Term evaluation
   // ==========================================================

   // One product term: good states of enabled sources, ANDed
   function automatic logic prodTerm(
      input odl_pkg::odl_term_t m,
      input logic hEn,
      input logic [5:0] pri,
      input logic [5:0] sec,
      input logic [1:0] wd,
      input logic [3:0] gp,
      input logic [5:0] oth,
      input logic hOk
   );
      logic [7:0] priSrc;
      logic [7:0] secSrc;
      logic [7:0] ioSrc;
      priSrc = {wd, pri};
      secSrc = {gp[1:0], sec};
      ioSrc = {oth, gp[3:2]};
      // Cleared mask bits force their source to true
      prodTerm = (&(~m.pri | priSrc)) & (&(~m.sec | secSrc)) & (&(~m.io | ioSrc))
         & (~hEn | hOk);
   endfunction

   odl_pkg::odl_state_t stateQ;
   odl_pkg::odl_state_t stateD;
   logic [7:0] regIdx;
   logic [7:0] wrByte;
   logic wrEn;
   logic [5:0] othForD;
   logic [5:0] othForE;
   logic termD1;
   logic termD2;
   logic termE1;
   logic termE2;
   logic mrLow;

   // Bus request fields
   assign regIdx = wbAdr[9:2];
   assign wrByte = wbDatI[7:0];
   assign wrEn = wbCyc & wbStb & wbWe & ~stateQ.ack & wbSel[0];
   assign mrLow = ~manualResetN;

   // Good states of other outputs; D and E come from flip-flops
   assign othForD = {~outGAssert, ~outFAssert, ~stateQ.outE, ~outCAssert, ~outBAssert, ~outAAssert};
   assign othForE = {~outGAssert, ~outFAssert, ~stateQ.outD, ~outCAssert, ~outBAssert, ~outAAssert};

   // Four product terms
   assign termD1 = prodTerm(stateQ.dT1, stateQ.hBitsA[`ODL_BIT_D_T1_H], monPriOk, monSecOk,
      wdogOk, gpInput, othForD, ~outHAssert);
   assign termD2 = prodTerm(stateQ.dT2, stateQ.hBitsA[`ODL_BIT_D_T2_H], monPriOk, monSecOk,
      wdogOk, gpInput, othForD, ~outHAssert);
   assign termE1 = prodTerm(stateQ.eT1, stateQ.hBitsB[`ODL_BIT_E_T1_H], monPriOk, monSecOk,
      wdogOk, gpInput, othForE, ~outHAssert);
   assign termE2 = prodTerm(stateQ.eT2, stateQ.eT2H[`ODL_BIT_E_T2_H], monPriOk, monSecOk,
      wdogOk, gpInput, othForE, ~outHAssert);

   // ==========================================================
   // Next state
   // ==========================================================

   // Register writes, read data, acknowledge and output levels
   always_comb
   begin
      stateD = stateQ;
      stateD.ack = wbCyc & wbStb & ~stateQ.ack;
      // Either term true deasserts; manual reset may force assertion
      stateD.outD = ~(termD1 | termD2) | (stateQ.mrEn[`ODL_BIT_MR_D] & mrLow);
      stateD.outE = ~(termE1 | termE2) | (stateQ.mrEn[`ODL_BIT_MR_E] & mrLow);
      if (wrEn)
      begin
         if (regIdx == `ODL_IDX_D_T1_PRI)
            stateD.dT1.pri = wrByte;
         else if (regIdx == `ODL_IDX_D_T1_SEC)
            stateD.dT1.sec = wrByte;
         else if (regIdx == `ODL_IDX_D_T1_IO)
            stateD.dT1.io = wrByte;
         else if (regIdx == `ODL_IDX_D_T2_PRI)
            stateD.dT2.pri = wrByte;
         else if (regIdx == `ODL_IDX_D_T2_SEC)
            stateD.dT2.sec = wrByte;
         else if (regIdx == `ODL_IDX_D_T2_IO)
            stateD.dT2.io = wrByte;
         else if (regIdx == `ODL_IDX_H_BITS_A)
            stateD.hBitsA = wrByte;
         else if (regIdx == `ODL_IDX_E_T1_PRI)
            stateD.eT1.pri = wrByte;
         else if (regIdx == `ODL_IDX_E_T1_SEC)
            stateD.eT1.sec = wrByte;
         else if (regIdx == `ODL_IDX_E_T1_IO)
            stateD.eT1.io = wrByte;
         else if (regIdx == `ODL_IDX_E_T2_PRI)
            stateD.eT2.pri = wrByte;
         else if (regIdx == `ODL_IDX_E_T2_SEC)
            stateD.eT2.sec = wrByte;
         else if (regIdx == `ODL_IDX_E_T2_IO)
            stateD.eT2.io = wrByte;
         else if (regIdx == `ODL_IDX_H_BITS_B)
            stateD.hBitsB = wrByte;
         else if (regIdx == `ODL_IDX_E_T2_H)
            stateD.eT2H = wrByte;
         else if (regIdx == `ODL_IDX_MR_EN)
            stateD.mrEn = wrByte;
      end
      // Read data; unmapped indexes read zero
      stateD.rdata = 32'h0000_0000;
      if (regIdx == `ODL_IDX_D_T1_PRI)
         stateD.rdata[7:0] = stateQ.dT1.pri;
      else if (regIdx == `ODL_IDX_D_T1_SEC)
         stateD.rdata[7:0] = stateQ.dT1.sec;
      else if (regIdx == `ODL_IDX_D_T1_IO)
         stateD.rdata[7:0] = stateQ.dT1.io;
      else if (regIdx == `ODL_IDX_D_T2_PRI)
         stateD.rdata[7:0] = stateQ.dT2.pri;
      else if (regIdx == `ODL_IDX_D_T2_SEC)
         stateD.rdata[7:0] = stateQ.dT2.sec;
      else if (regIdx == `ODL_IDX_D_T2_IO)
         stateD.rdata[7:0] = stateQ.dT2.io;
      else if (regIdx == `ODL_IDX_H_BITS_A)
         stateD.rdata[7:0] = stateQ.hBitsA;
      else if (regIdx == `ODL_IDX_E_T1_PRI)
         stateD.rdata[7:0] = stateQ.eT1.pri;
      else if (regIdx == `ODL_IDX_E_T1_SEC)
         stateD.rdata[7:0] = stateQ.eT1.sec;
      else if (regIdx == `ODL_IDX_E_T1_IO)
         stateD.rdata[7:0] = stateQ.eT1.io;
      else if (regIdx == `ODL_IDX_E_T2_PRI)
         stateD.rdata[7:0] = stateQ.eT2.pri;
      else if (regIdx == `ODL_IDX_E_T2_SEC)
         stateD.rdata[7:0] = stateQ.eT2.sec;
      else if (regIdx == `ODL_IDX_E_T2_IO)
         stateD.rdata[7:0] = stateQ.eT2.io;
      else if (regIdx == `ODL_IDX_H_BITS_B)
         stateD.rdata[7:0] = stateQ.hBitsB;
      else if (regIdx == `ODL_IDX_E_T2_H)
         stateD.rdata[7:0] = stateQ.eT2H;
      else if (regIdx == `ODL_IDX_MR_EN)
         stateD.rdata[7:0] = stateQ.mrEn;
      else if (regIdx == `ODL_IDX_STATUS)
         stateD.rdata[5:0] = {stateQ.outE, stateQ.outD, termE2, termE1, termD2, termD1};
   end

   // ==========================================================
   // State register
   // ==========================================================

   // All state held here; clock enable freezes it
   always_ff @(posedge refClk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stateQ <= '0;
      end
      else if (clkEn)
      begin
         stateQ <= stateD;
      end
   end

   // Outputs straight from flip-flops
   assign wbAck = stateQ.ack;
   assign wbDatO = stateQ.rdata;
   assign outDAssert = stateQ.outD;
   assign outEAssert = stateQ.outE;

endmodule

// [odl_output_dependency_assertions.sv]
// Port-level checker of the output dependency block
`timescale 1ns/10ps
module odl_output_dependency_assertions (
   input wire logic refClk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [9:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   input wire logic [31:0] wbDatO,
   input wire logic wbAck,
   input wire logic manualResetN,
   input wire logic outDAssert,
   input wire logic outEAssert
);
   // ===========================
   // Request taking and a shadow of the manual reset enables
   default clocking cb @(posedge refClk); endclocking
   default disable iff (!arst_n);
   logic [7:0] mrEnQ;
   wire take = clkEn && wbCyc && wbStb && !wbAck;
   wire mapped = wbAdr[9:2] inside {[8'h1D:8'h2A], 8'h3B, 8'h40, 8'h50};
   always_ff @(posedge refClk or negedge arst_n)
      if (!arst_n) mrEnQ <= 8'h00;
      else if (take && wbWe && wbSel[0] && wbAdr[9:2] == 8'h40) mrEnQ <= wbDatI[7:0];
   a_ack_next: assert property (take |=> wbAck)
      else $error("ack late");
   a_ack_pulse: assert property (clkEn && wbAck |=> !wbAck)
      else $error("ack too long");
   a_ack_quiet: assert property (clkEn && !wbStb |=> !wbAck)
      else $error("ack without request");
   a_data_upper: assert property (wbAck |-> wbDatO[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_unmapped_zero: assert property (take && !mapped ##1 wbAck |-> wbDatO == 32'h00000000)
      else $error("unmapped read not zero");
   a_mr_readback: assert property (take && !wbWe && wbAdr[9:2] == 8'h40 |=> wbDatO[7:0] == mrEnQ)
      else $error("enable readback wrong");
   a_mr_out_d: assert property (clkEn && mrEnQ[3] && !manualResetN |=> outDAssert)
      else $error("manual reset did not assert output D");
   a_mr_out_e: assert property (clkEn && mrEnQ[4] && !manualResetN |=> outEAssert)
      else $error("manual reset did not assert output E");
   cover property (take && wbWe);
   cover property (take && !mapped);
   cover property (outDAssert && outEAssert);
endmodule

// [odl_far_side.sv]
// Far-side model of rails, watchdogs, gp inputs and sibling outputs
`timescale 1ns/10ps
module odl_far_side (
   input wire logic [24:0] faultReq,
   output logic [5:0] monPriOk,
   output logic [5:0] monSecOk,
   output logic [1:0] wdogOk,
   output logic [3:0] gpInput,
   output logic [5:0] outAsserts,
   output logic manualResetN
);
   // ===========================
   // A faulty source reads not good; a faulty sibling output reads asserted
   assign {manualResetN, outAsserts, gpInput, wdogOk, monSecOk, monPriOk} =
      faultReq ^ 25'h103FFFF;
endmodule

// [odl_output_dependency_test.sv]
// Self-checking bench of the output dependency block
`timescale 1ns/10ps
module odl_output_dependency_test;
   logic refClk = 1'b0;
   logic arst_n = 1'b0;
   logic clkEn = 1'b1;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [9:0] wbAdr = 10'h000;
   logic [3:0] wbSel = 4'hF;
   logic [31:0] wbDatI = 32'h00000000;
   logic [31:0] wbDatO;
   logic wbAck, outDAssert, outEAssert, manualResetN;
   logic [24:0] faultReq = 25'h0000000;
   logic [5:0] monPriOk, monSecOk, outAsserts;
   logic [1:0] wdogOk;
   logic [3:0] gpInput;
   logic [7:0] rd;
   int nMismatch = 0;
   int checkCount = 0;
   localparam logic [24:0] BASE = 25'h0002000; // Watchdog two kept in fault
   // Rows: index, mask, fault bit, expected {D, E}
   logic [31:0] rows [25] = '{32'h20010002, 32'h20200502, 32'h20010D00, 32'h20000000,
      32'h20400C02, 32'h20800D02, 32'h21010602, 32'h21200B02, 32'h21400E02,
      32'h22021102, 32'h22041202, 32'h22801602, 32'h23021702, 32'h23011700,
      32'h24010001, 32'h24800D01, 32'h25200B01, 32'h25800F01, 32'h26011001,
      32'h26041201, 32'h26801601, 32'h2A011701, 32'h40081802, 32'h40101801,
      32'h40080D00};
   logic [7:0] regIdx [16] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
      8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h3B, 8'h40};
   // ===========================
   // Design, far side and clock
   odl_output_dependency DUT (.refClk, .arst_n, .clkEn, .wbCyc, .wbStb, .wbWe, .wbAdr,
      .wbSel, .wbDatI, .wbDatO, .wbAck, .monPriOk, .monSecOk, .wdogOk, .gpInput,
      .outAAssert(outAsserts[0]), .outBAssert(outAsserts[1]), .outCAssert(outAsserts[2]),
      .outFAssert(outAsserts[3]), .outGAssert(outAsserts[4]), .outHAssert(outAsserts[5]),
      .manualResetN, .outDAssert, .outEAssert);
   odl_far_side farSide (.faultReq, .monPriOk, .monSecOk, .wdogOk, .gpInput, .outAsserts,
      .manualResetN);
   initial forever #2.5 refClk = ~refClk;
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checkCount++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Classic single cycle, held until ack is sampled high
   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      int n = 0;
      @(posedge refClk);
      {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, idx, 2'b00, 24'h000000, wd};
      do @(posedge refClk); while (wbAck !== 1'b1 && ++n < 20);
      if (n == 20) nMismatch++;
      rd = wbDatO[7:0];
      {wbCyc, wbStb} <= 2'b00;
   endtask
   task automatic settle(input logic [24:0] f, input logic d, input logic e);
      faultReq <= f;
      repeat (3) @(posedge refClk);
      check("outD", 8'(d), 8'(outDAssert));
      check("outE", 8'(e), 8'(outEAssert));
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #20us;
      nMismatch++;
      report_and_stop();
   end
   // ===========================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge refClk);
      arst_n <= 1'b1;
      foreach (regIdx[i])
      begin
         bus(1'b0, regIdx[i], 8'h00);
         check("reset value", 8'h00, rd);
         bus(1'b1, regIdx[i], 8'hA5);
         bus(1'b0, regIdx[i], 8'h00);
         check("readback", 8'hA5, rd);
         bus(1'b1, regIdx[i], 8'h00);
      end
      bus(1'b1, 8'h1D, 8'h80);
      bus(1'b1, 8'h27, 8'h80);
      settle(BASE, 1'b0, 1'b0);
      // Status: D term 1 and E term 2 fail on watchdog two, the others hold
      bus(1'b0, 8'h50, 8'h00);
      check("status", 8'h06, rd);
      foreach (rows[i])
      begin
         bus(1'b1, rows[i][31:24], rows[i][23:16]);
         settle(BASE | (25'h1 << rows[i][15:8]), rows[i][1], rows[i][0]);
         bus(1'b1, rows[i][31:24], 8'h00);
         settle(BASE, 1'b0, 1'b0);
      end
      bus(1'b1, 8'h30, 8'hFF);
      bus(1'b0, 8'h30, 8'h00);
      check("unmapped", 8'h00, rd);
      wbSel <= 4'hE;
      bus(1'b1, 8'h40, 8'h18);
      wbSel <= 4'hF;
      bus(1'b0, 8'h40, 8'h00);
      check("masked write", 8'h00, rd);
      bus(1'b1, 8'h24, 8'h01);
      bus(1'b1, 8'h22, 8'h20);
      settle(BASE | 25'h1, 1'b1, 1'b1);
      // Clock enable low: a cleared fault must not reach the outputs
      clkEn <= 1'b0;
      faultReq <= BASE;
      repeat (3) @(posedge refClk);
      check("frozen outD", 8'h01, 8'(outDAssert));
      check("frozen outE", 8'h01, 8'(outEAssert));
      clkEn <= 1'b1;
      faultReq <= BASE | 25'h1;
      arst_n <= 1'b0;
      @(posedge refClk);
      check("reset outD", 8'h00, 8'(outDAssert));
      check("reset outE", 8'h00, 8'(outEAssert));
      arst_n <= 1'b1;
      bus(1'b0, 8'h22, 8'h00);
      check("mask after reset", 8'h00, rd);
      report_and_stop();
   end
endmodule
bind odl_output_dependency odl_output_dependency_assertions chk (.refClk, .arst_n, .clkEn,
   .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .manualResetN,
   .outDAssert, .outEAssert);
